// ### core/sbl_pkg.sv
// constants, types and decode helpers for the sixteen-bit load sequencer
// assumes one clock, where one clock period is one T state
//
// How it works
// - 00pp0001 loads two immediate bytes into selected pair, 10 T states.
// - pair selector: 00 pair zero, 01 pair one, 10 pointer, 11 stack.
// - first operand byte is low order, second is high order.
// - DD 21 / FD 21 load immediate into index x / y, 14 T states.
// - opcode 2A loads pointer pair from nn and nn+1, 16 T states.
// - ED 01pp1011 loads selected pair from nn and nn+1, 20 T states.
// - DD/FD 2A loads index x/y from nn and nn+1, 20 T states.
// - opcode 22 stores pointer pair to nn and nn+1, 16 T states.
// - ED 01pp0011 stores selected pair to nn and nn+1, 20 T states.
// - DD 22 stores index x to nn and nn+1, 20 T states.
// - these instructions never change the flag register.
package sbl_pkg;

    // ========================================================
    // timing, in T states
    localparam int T_FETCH      = 4;
    localparam int T_MEM        = 3;
    localparam int T_IMM_PAIR   = 10;
    localparam int T_IMM_INDEX  = 14;
    localparam int T_PTR_MEM    = 16;
    localparam int T_LONG_MEM   = 20;

    // ========================================================
    // opcodes and reset values
    localparam logic [7:0]  OP_PREFIX_X   = 8'hDD;
    localparam logic [7:0]  OP_PREFIX_Y   = 8'hFD;
    localparam logic [7:0]  OP_PREFIX_EXT = 8'hED;
    localparam logic [7:0]  OP_IMM_INDEX  = 8'h21;
    localparam logic [7:0]  OP_LOAD_MEM   = 8'h2A;
    localparam logic [7:0]  OP_STORE_MEM  = 8'h22;
    localparam logic [15:0] RESET_PC      = 16'h0000;
    localparam logic [15:0] REG_RESET     = 16'h0000;
    localparam logic [7:0]  FLAG_RESET    = 8'h00;

    // ========================================================
    // types
    typedef enum logic [1:0] {PFX_NONE, PFX_X, PFX_Y, PFX_EXT} sbl_prefix_type;
    typedef enum logic [1:0] {KIND_NONE, KIND_IMM, KIND_LOAD, KIND_STORE} sbl_kind_type;
    typedef enum logic [2:0] {TGT_PAIR0, TGT_PAIR1, TGT_PTR, TGT_SP, TGT_IX, TGT_IY} sbl_target_type;

    typedef struct packed {
        sbl_kind_type   kind;
        sbl_target_type target;
    } sbl_decode_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        fetch;
        logic        rd;
        logic        wr;
    } sbl_bus_type;

    typedef struct packed {
        logic [15:0] general_pair_zero;
        logic [15:0] general_pair_one;
        logic [15:0] pointer_pair;
        logic [15:0] stack_pointer;
        logic [15:0] index_x;
        logic [15:0] index_y;
    } sbl_regs_type;

    // ========================================================
    // decode
    function automatic sbl_decode_type sbl_decode(input sbl_prefix_type pfx, input logic [7:0] op);
        sbl_decode_type d;
        sbl_target_type sel;
        sbl_target_type idx;
        d.kind   = KIND_NONE;
        d.target = TGT_PAIR0;
        sel      = sbl_target_type'({1'b0, op[5:4]});
        idx      = (pfx == PFX_Y) ? TGT_IY : TGT_IX;
        unique case (pfx)
            PFX_NONE: begin
                if (op[7:6] == 2'h0 && op[3:0] == 4'h1) begin
                    d.kind   = KIND_IMM;
                    d.target = sel;
                end else if (op == OP_LOAD_MEM) begin
                    d.kind   = KIND_LOAD;
                    d.target = TGT_PTR;
                end else if (op == OP_STORE_MEM) begin
                    d.kind   = KIND_STORE;
                    d.target = TGT_PTR;
                end
            end
            PFX_X, PFX_Y: begin
                d.target = idx;
                if (op == OP_IMM_INDEX) d.kind = KIND_IMM;
                else if (op == OP_LOAD_MEM) d.kind = KIND_LOAD;
                else if (op == OP_STORE_MEM && pfx == PFX_X) d.kind = KIND_STORE;
            end
            PFX_EXT: begin
                d.target = sel;
                if (op[7:6] == 2'h1 && op[3:0] == 4'hB) d.kind = KIND_LOAD;
                else if (op[7:6] == 2'h1 && op[3:0] == 4'h3) d.kind = KIND_STORE;
            end
        endcase
        return d;
    endfunction : sbl_decode

    function automatic logic [1:0] sbl_prefix_code(input logic [7:0] op);
        return (op == OP_PREFIX_X) ? 2'h1 : (op == OP_PREFIX_Y) ? 2'h2 : (op == OP_PREFIX_EXT) ? 2'h3 : 2'h0;
    endfunction : sbl_prefix_code

endpackage : sbl_pkg

// ### core/sbl_mcycle_timer.sv
// T-state counter inside one machine cycle
// assumes fetch_cycle holds steady for the whole machine cycle
`timescale 1ns/10ps
module sbl_mcycle_timer (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       fetch_cycle,
    output logic [2:0]      t_state,
    output logic            last
);

    // ========================================================
    // counter
    assign last = fetch_cycle ? (t_state == 3'(sbl_pkg::T_FETCH - 1))
                              : (t_state == 3'(sbl_pkg::T_MEM - 1));

    always_ff @(posedge ref_clk) begin
        if (rst) t_state <= 3'h0;
        else if (last) t_state <= 3'h0;
        else t_state <= t_state + 3'h1;
    end

    // ========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_fetch_len;
        (t_state == 3'h0 && fetch_cycle) |-> !last [*3] ##1 last;
    endproperty
    a_fetch_len: assert property (p_fetch_len) else $error("fetch cycle not 4 T states");

    property p_mem_len;
        (t_state == 3'h0 && !fetch_cycle) |-> !last [*2] ##1 last;
    endproperty
    a_mem_len: assert property (p_mem_len) else $error("memory cycle not 3 T states");

endmodule : sbl_mcycle_timer

// ### core/sbl_load_sequencer.sv
// sixteen-bit load group: fetch, decode and machine-cycle sequencing
// assumes a synchronous byte memory on ref_clk: read data valid at the last T state
`timescale 1ns/10ps
module sbl_load_sequencer (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           mem_rdata,
    input  wire logic                 flag_load,
    input  wire logic [7:0]           flag_value,
    output sbl_pkg::sbl_bus_type      bus,
    output sbl_pkg::sbl_regs_type     regs_out,
    output logic [7:0]                flags,
    output logic                      instr_done
);

    typedef enum logic [2:0] {ST_FETCH, ST_FETCH2, ST_OPER_LO, ST_OPER_HI, ST_DATA_LO, ST_DATA_HI} sbl_state_type;

    sbl_state_type          state;
    sbl_pkg::sbl_prefix_type prefix;
    sbl_pkg::sbl_kind_type  kind;
    sbl_pkg::sbl_target_type target;
    sbl_pkg::sbl_decode_type cur_dec;
    logic [15:0]            pc;
    logic [7:0]             lo_byte;
    logic [15:0]            regs [6];
    logic [2:0]             t_state;
    logic                   mc_last;
    logic                   fetching;
    logic                   is_prefix;
    logic                   reg_we;
    logic [15:0]            reg_wval;
    logic [15:0]            sel_reg;
    logic [4:0]             tcount;

    // ========================================================
    // machine cycle timing
    assign fetching = (state == ST_FETCH) || (state == ST_FETCH2);

    sbl_mcycle_timer u_timer (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .fetch_cycle (fetching),
        .t_state     (t_state),
        .last        (mc_last)
    );

    // ========================================================
    // decode of the byte on the bus
    assign is_prefix = fetching && (sbl_pkg::sbl_prefix_code(mem_rdata) != 2'h0);
    assign cur_dec   = sbl_pkg::sbl_decode((state == ST_FETCH) ? sbl_pkg::PFX_NONE : prefix, mem_rdata);
    assign sel_reg   = regs[target];

    assign instr_done = mc_last && ((fetching && !is_prefix && cur_dec.kind == sbl_pkg::KIND_NONE)
                      || (state == ST_OPER_HI && kind == sbl_pkg::KIND_IMM)
                      || state == ST_DATA_HI);

    // ========================================================
    // sequencing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state  <= ST_FETCH;
            prefix <= sbl_pkg::PFX_NONE;
            kind   <= sbl_pkg::KIND_NONE;
            target <= sbl_pkg::TGT_PAIR0;
        end else if (mc_last) begin
            unique case (state)
                ST_FETCH, ST_FETCH2: begin
                    if (is_prefix) begin
                        prefix <= sbl_pkg::sbl_prefix_type'(sbl_pkg::sbl_prefix_code(mem_rdata));
                        state  <= ST_FETCH2;
                    end else if (cur_dec.kind == sbl_pkg::KIND_NONE) begin
                        prefix <= sbl_pkg::PFX_NONE;
                        state  <= ST_FETCH;
                    end else begin
                        if (state == ST_FETCH) prefix <= sbl_pkg::PFX_NONE;
                        kind   <= cur_dec.kind;
                        target <= cur_dec.target;
                        state  <= ST_OPER_LO;
                    end
                end
                ST_OPER_LO: state <= ST_OPER_HI;
                ST_OPER_HI: state <= (kind == sbl_pkg::KIND_IMM) ? ST_FETCH : ST_DATA_LO;
                ST_DATA_LO: state <= ST_DATA_HI;
                ST_DATA_HI: state <= ST_FETCH;
            endcase
        end
    end

    // ========================================================
    // program counter
    always_ff @(posedge ref_clk) begin
        if (rst) pc <= sbl_pkg::RESET_PC;
        else if (mc_last && (fetching || state == ST_OPER_LO || state == ST_OPER_HI)) pc <= pc + 16'h1;
    end

    // ========================================================
    // operand and data low byte
    always_ff @(posedge ref_clk) begin
        if (rst) lo_byte <= 8'h00;
        else if (mc_last && (state == ST_OPER_LO || state == ST_DATA_LO)) lo_byte <= mem_rdata;
    end

    // ========================================================
    // bus address, write data and strobes for the next machine cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus.addr  <= sbl_pkg::RESET_PC;
            bus.wdata <= 8'h00;
            bus.fetch <= 1'b1;
            bus.rd    <= 1'b1;
            bus.wr    <= 1'b0;
        end else if (mc_last) begin
            bus.addr  <= pc + 16'h1;
            bus.fetch <= 1'b0;
            bus.rd    <= 1'b1;
            bus.wr    <= 1'b0;
            unique case (state)
                ST_FETCH, ST_FETCH2: bus.fetch <= is_prefix || cur_dec.kind == sbl_pkg::KIND_NONE;
                ST_OPER_LO: ;
                ST_OPER_HI: begin
                    if (kind == sbl_pkg::KIND_IMM) begin
                        bus.fetch <= 1'b1;
                    end else begin
                        bus.addr  <= {mem_rdata, lo_byte};
                        bus.rd    <= (kind == sbl_pkg::KIND_LOAD);
                        bus.wr    <= (kind == sbl_pkg::KIND_STORE);
                        bus.wdata <= sel_reg[7:0];
                    end
                end
                ST_DATA_LO: begin
                    bus.addr  <= bus.addr + 16'h1;
                    bus.rd    <= (kind == sbl_pkg::KIND_LOAD);
                    bus.wr    <= (kind == sbl_pkg::KIND_STORE);
                    bus.wdata <= sel_reg[15:8];
                end
                ST_DATA_HI: begin
                    bus.addr  <= pc;
                    bus.fetch <= 1'b1;
                end
            endcase
        end
    end

    // ========================================================
    // register file
    assign reg_we   = mc_last && ((state == ST_OPER_HI && kind == sbl_pkg::KIND_IMM)
                    || (state == ST_DATA_HI && kind == sbl_pkg::KIND_LOAD));
    assign reg_wval = {mem_rdata, lo_byte};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < 6; i++) regs[i] <= sbl_pkg::REG_RESET;
        end else if (reg_we) begin
            regs[target] <= reg_wval;
        end
    end

    assign regs_out = {regs[0], regs[1], regs[2], regs[3], regs[4], regs[5]};

    // ========================================================
    // flag register, written only by other instruction groups
    always_ff @(posedge ref_clk) begin
        if (rst) flags <= sbl_pkg::FLAG_RESET;
        else if (flag_load) flags <= flag_value;
    end

    // ========================================================
    // checks
    always_ff @(posedge ref_clk) begin
        if (rst) tcount <= 5'h1;
        else if (instr_done) tcount <= 5'h1;
        else tcount <= tcount + 5'h1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_imm_pair;
        (instr_done && state == ST_OPER_HI && prefix == sbl_pkg::PFX_NONE) |-> tcount == 5'(sbl_pkg::T_IMM_PAIR);
    endproperty
    a_imm_pair: assert property (p_imm_pair) else $error("immediate pair load wrong length");

    property p_pair_select;
        (state == ST_FETCH && mc_last && cur_dec.kind == sbl_pkg::KIND_IMM)
            |=> target == sbl_pkg::sbl_target_type'({1'b0, $past(mem_rdata[5:4])});
    endproperty
    a_pair_select: assert property (p_pair_select) else $error("pair selector decoded wrongly");

    property p_addr_order;
        (state == ST_OPER_HI && mc_last && kind != sbl_pkg::KIND_IMM)
            |=> bus.addr == {$past(mem_rdata), $past(lo_byte)} && state == ST_DATA_LO;
    endproperty
    a_addr_order: assert property (p_addr_order) else $error("operand byte order wrong");

    property p_imm_index;
        (instr_done && state == ST_OPER_HI && prefix != sbl_pkg::PFX_NONE)
            |-> tcount == 5'(sbl_pkg::T_IMM_INDEX) && target inside {sbl_pkg::TGT_IX, sbl_pkg::TGT_IY};
    endproperty
    a_imm_index: assert property (p_imm_index) else $error("index immediate load wrong");

    property p_load_ptr;
        (instr_done && state == ST_DATA_HI && kind == sbl_pkg::KIND_LOAD && prefix == sbl_pkg::PFX_NONE)
            |-> tcount == 5'(sbl_pkg::T_PTR_MEM) ##1 regs[sbl_pkg::TGT_PTR] == {$past(mem_rdata), $past(lo_byte)};
    endproperty
    a_load_ptr: assert property (p_load_ptr) else $error("pointer load wrong");

    property p_load_ext;
        (instr_done && state == ST_DATA_HI && kind == sbl_pkg::KIND_LOAD && prefix == sbl_pkg::PFX_EXT)
            |-> tcount == 5'(sbl_pkg::T_LONG_MEM);
    endproperty
    a_load_ext: assert property (p_load_ext) else $error("selected pair load wrong length");

    property p_load_index;
        (instr_done && state == ST_DATA_HI && kind == sbl_pkg::KIND_LOAD && prefix inside {sbl_pkg::PFX_X, sbl_pkg::PFX_Y})
            |-> tcount == 5'(sbl_pkg::T_LONG_MEM);
    endproperty
    a_load_index: assert property (p_load_index) else $error("index load wrong length");

    property p_store_ptr;
        (instr_done && state == ST_DATA_HI && kind == sbl_pkg::KIND_STORE && prefix == sbl_pkg::PFX_NONE)
            |-> tcount == 5'(sbl_pkg::T_PTR_MEM) && bus.wr && bus.wdata == regs[sbl_pkg::TGT_PTR][15:8];
    endproperty
    a_store_ptr: assert property (p_store_ptr) else $error("pointer store wrong");

    property p_store_ext;
        (instr_done && state == ST_DATA_HI && kind == sbl_pkg::KIND_STORE && prefix == sbl_pkg::PFX_EXT)
            |-> tcount == 5'(sbl_pkg::T_LONG_MEM) && bus.wdata == sel_reg[15:8];
    endproperty
    a_store_ext: assert property (p_store_ext) else $error("selected pair store wrong");

    property p_store_index;
        (instr_done && state == ST_DATA_HI && kind == sbl_pkg::KIND_STORE && prefix == sbl_pkg::PFX_X)
            |-> tcount == 5'(sbl_pkg::T_LONG_MEM) && target == sbl_pkg::TGT_IX;
    endproperty
    a_store_index: assert property (p_store_index) else $error("index store wrong");

    property p_flags_kept;
        !flag_load |=> $stable(flags);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed without a load");

    property p_addr_wrap;
        (state == ST_DATA_LO && mc_last) |=> bus.addr == 16'($past(bus.addr) + 16'h1);
    endproperty
    a_addr_wrap: assert property (p_addr_wrap) else $error("second address not nn+1");

    c_imm_pair:  cover property (instr_done && state == ST_OPER_HI && prefix == sbl_pkg::PFX_NONE);
    c_load_ext:  cover property (instr_done && state == ST_DATA_HI && kind == sbl_pkg::KIND_LOAD && prefix == sbl_pkg::PFX_EXT);
    c_store_x:   cover property (instr_done && state == ST_DATA_HI && kind == sbl_pkg::KIND_STORE && prefix == sbl_pkg::PFX_X);
    c_wrap:      cover property (state == ST_DATA_LO && mc_last && bus.addr == 16'hFFFF);

endmodule : sbl_load_sequencer

// ### bench/sbl_memory_model.sv
// byte-wide external memory on the processor bus, behavioural
// assumes the sequencer's bus struct and one shared clock, no wait states
`timescale 1ns/10ps
module sbl_memory_model (
    input  wire logic                 ref_clk,
    input  wire sbl_pkg::sbl_bus_type bus,
    output logic [7:0]                mem_rdata
);
    // ========================================================
    // storage and read path
    logic [7:0] mem [0:65535];
    logic [7:0] last_rdata;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
        end
        last_rdata = 8'h00;
    end

    // each byte lands at the address the device puts out
    always @(posedge ref_clk) begin
        if (bus.wr) begin
            mem[bus.addr] <= bus.wdata;
        end
        if (bus.rd) begin
            last_rdata <= mem[bus.addr];
        end
    end

    // released bus shows the inverse of the last byte, never a stale copy
    assign mem_rdata = bus.rd ? mem[bus.addr] : ~last_rdata;
endmodule : sbl_memory_model

// ### bench/test_sbl_load_sequencer.sv
// self-checking bench for the sixteen-bit load sequencer
// assumes the memory model beside it; program built at time zero
`timescale 1ns/10ps
module test_sbl_load_sequencer;
    typedef struct {int len; sbl_pkg::sbl_regs_type regs;} sbl_note_type;
    typedef struct {logic [15:0] addr; logic [7:0] data;} sbl_wnote_type;

    logic                  ref_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  flag_load = 1'b0;
    logic [7:0]            flag_value = 8'h00;
    logic [7:0]            mem_rdata;
    logic [7:0]            flags;
    logic [7:0]            exp_flags = 8'h00;
    logic                  instr_done;
    sbl_pkg::sbl_bus_type  bus;
    sbl_pkg::sbl_regs_type regs_out;
    sbl_pkg::sbl_regs_type er;
    sbl_pkg::sbl_regs_type pend_regs;
    logic [15:0]           pc = 16'h0000;
    logic [7:0]            img [logic [15:0]];
    logic [7:0]            xm [logic [15:0]];
    logic [15:0]           a_q = 16'h0000;
    sbl_note_type          notes[$];
    sbl_wnote_type         wnotes[$];
    int                    miscompares = 0;
    int                    n_tests = 0;
    int                    seed = 18499;
    int                    cyc = 0;
    int                    cnt = 0;
    int                    wl = 0;
    int                    fl = 0;
    logic                  pend = 1'b0;
    logic                  wr_q = 1'b0;

    sbl_load_sequencer uut (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .mem_rdata  (mem_rdata),
        .flag_load  (flag_load),
        .flag_value (flag_value),
        .bus        (bus),
        .regs_out   (regs_out),
        .flags      (flags),
        .instr_done (instr_done)
    );

    sbl_memory_model mdl (
        .ref_clk   (ref_clk),
        .bus       (bus),
        .mem_rdata (mem_rdata)
    );

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // ========================================================
    // compare tasks
    task automatic fail(string msg);
        miscompares++;
        $display("[FAIL] t=%0t %s", $time, msg);
    endtask : fail

    task automatic cmp_regs(sbl_pkg::sbl_regs_type got, sbl_pkg::sbl_regs_type exp);
        n_tests++;
        if (got !== exp) fail($sformatf("regs %h exp %h", got, exp));
    endtask : cmp_regs

    task automatic cmp_byte(logic [7:0] got, logic [7:0] exp, string what);
        n_tests++;
        if (got !== exp) fail($sformatf("%s %h exp %h", what, got, exp));
    endtask : cmp_byte

    task automatic cmp_addr(logic [15:0] got, logic [15:0] exp);
        n_tests++;
        if (got !== exp) fail($sformatf("write addr %h exp %h", got, exp));
    endtask : cmp_addr

    task automatic cmp_int(int got, int exp, string what);
        n_tests++;
        if (got != exp) fail($sformatf("%s %0d exp %0d", what, got, exp));
    endtask : cmp_int

    // ========================================================
    // program builder: memory image plus expected notes
    function automatic logic [7:0] rd(logic [15:0] a);
        return xm.exists(a) ? xm[a] : img.exists(a) ? img[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
    endfunction : rd

    task automatic emit(logic [7:0] b);
        img[pc] = b;
        pc = pc + 16'h0001;
    endtask : emit

    task automatic head(logic [7:0] pfx, logic [7:0] op);
        if (pfx !== 8'h00) emit(pfx);
        emit(op);
    endtask : head

    task automatic note(int len);
        notes.push_back('{len, er});
    endtask : note

    task automatic imm(logic [7:0] pfx, logic [7:0] op, int t, int len);
        logic [15:0] v;
        v = 16'($random(seed));
        head(pfx, op);
        emit(v[7:0]);
        emit(v[15:8]);
        er[95-16*t -: 16] = v;
        note(len);
    endtask : imm

    task automatic ld(logic [7:0] pfx, logic [7:0] op, int t, logic [15:0] nn, int len);
        head(pfx, op);
        emit(nn[7:0]);
        emit(nn[15:8]);
        er[95-16*t -: 16] = {rd(nn + 16'h0001), rd(nn)};
        note(len);
    endtask : ld

    task automatic st(logic [7:0] pfx, logic [7:0] op, int t, logic [15:0] nn, int len);
        logic [15:0] v;
        v = er[95-16*t -: 16];
        head(pfx, op);
        emit(nn[7:0]);
        emit(nn[15:8]);
        // expected memory only: a later load from nn proves the 22 and DD 22 stores landed
        xm[nn] = v[7:0];
        xm[nn + 16'h0001] = v[15:8];
        wnotes.push_back('{nn, v[7:0]});
        wnotes.push_back('{nn + 16'h0001, v[15:8]});
        note(len);
    endtask : st

    function automatic logic [15:0] rnd_nn();
        return 16'h8000 | (16'($random(seed)) & 16'h7FF0);
    endfunction : rnd_nn

    // ========================================================
    // inputs: reset, random flag writes, flag check
    always @(negedge ref_clk) begin
        exp_flags = rst ? 8'h00 : (flag_load ? flag_value : exp_flags);
        cmp_byte(flags, exp_flags, "flags");
        cyc++;
        rst = (cyc < 5);
        flag_load = (($random(seed) & 7) == 0);
        flag_value = 8'($random(seed));
    end

    // ========================================================
    // output watcher
    always @(negedge ref_clk) begin
        sbl_note_type  nt;
        sbl_wnote_type w;
        cnt++;
        if (pend) begin
            cmp_regs(regs_out, pend_regs);
            pend = 1'b0;
        end
        if (instr_done === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt.len > 0) cmp_int(cnt, nt.len, "length");
            pend = 1'b1;
            pend_regs = nt.regs;
            cnt = 0;
        end
        // both data cycles of a store keep the strobe high; a new address starts a new cycle
        if (bus.wr === 1'b1 && (!wr_q || bus.addr !== a_q)) begin
            if (wl != 0) cmp_int(wl, 3, "write cycle");
            wl = 0;
            cmp_byte({7'h00, bus.rd}, 8'h00, "read strobe");
            if (wnotes.size() > 0) begin
                w = wnotes.pop_front();
                cmp_addr(bus.addr, w.addr);
                cmp_byte(bus.wdata, w.data, "write data");
            end
        end
        if (bus.wr === 1'b1) wl++;
        else if (wl != 0) begin
            cmp_int(wl, 3, "write cycle");
            wl = 0;
        end
        if (bus.fetch === 1'b1) fl++;
        else if (fl != 0) begin
            cmp_int(fl % 4, 0, "fetch run");
            fl = 0;
        end
        wr_q = (bus.wr === 1'b1);
        a_q = bus.addr;
    end

    // ========================================================
    // closing
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        logic [15:0] nn;
        int          i;
        er = '0;
        emit(8'h00);
        note(-1);
        for (int p = 0; p < 4; p++) begin
            imm(8'h00, {2'b00, 2'(p), 4'h1}, p, 10);
        end
        imm(8'hDD, 8'h21, 4, 14);
        imm(8'hFD, 8'h21, 5, 14);
        ld(8'h00, 8'h2A, 2, 16'hFFFF, 16);
        for (int p = 0; p < 4; p++) begin
            st(8'hED, {2'b01, 2'(p), 4'h3}, p, rnd_nn(), 20);
            ld(8'hED, {2'b01, 2'(p), 4'hB}, p, rnd_nn(), 20);
        end
        nn = rnd_nn();
        st(8'h00, 8'h22, 2, nn, 16);
        ld(8'hDD, 8'h2A, 4, nn, 20);
        ld(8'hFD, 8'h2A, 5, rnd_nn(), 20);
        nn = rnd_nn();
        st(8'hDD, 8'h22, 4, nn, 20);
        ld(8'h00, 8'h2A, 2, nn, 16);
        emit(8'h00);
        note(4);
        #1;
        foreach (img[k]) mdl.mem[k] = img[k];
        for (i = 0; i < 5000 && (notes.size() > 0 || pend); i++) @(posedge ref_clk);
        #1;
        if (notes.size() > 0 || wnotes.size() > 0) fail("program did not complete");
        $display("test load group sequence done");
        tally_and_finish();
    end
endmodule : test_sbl_load_sequencer
